// ===== design/sbcs_consts.svh
`ifndef SBCS_CONSTS_SVH
`define SBCS_CONSTS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SBCS_FRAME_BITS 5'h10
`define SBCS_CNT_SAT 5'h11
`define SBCS_ADDR_LOAD_FALLS 5'h08
`define SBCS_ADDR_MSB 6
`define SBCS_RW_BIT 7
`define SBCS_DATA_LSB 8
`define SBCS_DATA_MSB 15

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SBCS_ADDR_NONE 7'h00
`define SBCS_ADDR_MODE 7'h01
`define SBCS_ADDR_WD 7'h03
`define SBCS_ADDR_BUS_ONE 7'h04
`define SBCS_ADDR_WAKE_TWO 7'h07
`define SBCS_ADDR_CTRL_LAST 7'h1E
`define SBCS_ADDR_SUPPLY 7'h41
`define SBCS_ADDR_THERMAL 7'h42
`define SBCS_ADDR_DEVICE 7'h43
`define SBCS_ADDR_BUS_STAT_ONE 7'h44
`define SBCS_ADDR_BUS_STAT_TWO 7'h45
`define SBCS_ADDR_WAKE_STAT_ONE 7'h46
`define SBCS_ADDR_WAKE_STAT_TWO 7'h47
`define SBCS_ADDR_LEVEL 7'h48
`define SBCS_ADDR_SWITCHER 7'h4C
`define SBCS_ADDR_FAMILY 7'h7E

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SBCS_MODE_HI 7
`define SBCS_MODE_LO 6
`define SBCS_MODE_NORMAL 2'h0
`define SBCS_MODE_SLEEP 2'h1
`define SBCS_MODE_STOP 2'h2
`define SBCS_MODE_RESET 2'h3
`define SBCS_FAIL_BIT 1
`define SBCS_BYTE_ZERO 8'h00
`define SBCS_WORD_ZERO 16'h0000

`endif

// ===== design/sbcs_pkg.sv
package sbcs_pkg;

    // Operating mode reported by the chip's mode logic
    typedef enum logic [2:0]
    {
        SBCS_INIT,
        SBCS_NORMAL,
        SBCS_STOP,
        SBCS_SLEEP,
        SBCS_RESTART,
        SBCS_FAILSAFE
    } sbcs_mode_t;

    // Mode change handed to the mode logic
    typedef enum logic [2:0]
    {
        SBCS_GO_NORMAL,
        SBCS_GO_SLEEP,
        SBCS_GO_STOP,
        SBCS_GO_SWRESET,
        SBCS_GO_RESTART
    } sbcs_target_t;

    typedef struct packed
    {
        logic [7:0] data;
        logic rw;
        logic [6:0] addr;
    } sbcs_cmd_t;

    typedef struct packed
    {
        logic [7:0] family;
        logic [7:0] switcher;
        logic [7:0] level;
        logic [7:0] wake_two;
        logic [7:0] wake_one;
        logic [7:0] bus_two;
        logic [7:0] bus_one;
        logic [7:0] device;
        logic [7:0] thermal;
        logic [7:0] supply;
    } sbcs_status_t;

endpackage

// ===== design/sbcs_sync.sv
`timescale 1ns/100ps

// Three-stage input synchroniser; output moves once stages two and three agree
module sbcs_sync
#(
    parameter logic RST_VAL = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);

    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            q <= RST_VAL;
        end
        else if (ce)
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                q <= s3;
        end
    end

endmodule

// ===== design/sbcs_spi_target.sv
// Notes on behaviour
// - Sixteen bits in, sixteen bits out per frame
// - Word interpreted only on chip select rise
// - Serial output released when chip select rises
// - Serial input sampled on falling clock edges
// - Serial output advances after rising clock edges
// - Invalid command ignored, sticky fail flag set
// - Sleep from stop fails, goes restart
// - Stop or sleep from init fails, normal
// - Stop mode refuses watchdog setting changes
// - Sleep with no wake sources fails, restart
// - Stop with no wake sources is accepted
// - Only zero or sixteen clocks accepted
// - Bad frame ignored, error shown next frame
// - Zero-clock frame valid, raises no error
// - Address low seven, access bit, data high
// - Byte-wise access, bits kept until cleared
// - No interpretation in restart, sleep, fail-safe
// - Status read returns current content
// - Control read returns pre-frame value
// - Summary byte ORs each status register but level and family
// - Summary bits map registers in order
// - Access bit set clears status byte, level excepted
`timescale 1ns/100ps
`include "sbcs_consts.svh"

module sbcs_spi_target
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CLOCK_EN,
    input wire logic CHIP_SELECT_N,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_IN,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_EN,
    input wire sbcs_pkg::sbcs_mode_t CURRENT_MODE,
    input wire sbcs_pkg::sbcs_status_t STATUS,
    output logic SPI_FAIL,
    output logic ERR_PENDING,
    output logic MODE_REQ_STB,
    output sbcs_pkg::sbcs_target_t MODE_REQ,
    output logic WRITE_STB,
    output logic CLEAR_STB,
    output sbcs_pkg::sbcs_cmd_t CMD
);

    // ----------------------------------------
    // Reset release and input sampling
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;
    logic ce;
    logic csn_f;
    logic sclk_f;
    logic sdi_f;

    assign ce = CLOCK_EN;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    sbcs_sync #(.RST_VAL(1'b1)) u_csn
    (
        .clk(CLOCK),
        .rst_n(rst_n),
        .ce(ce),
        .d(CHIP_SELECT_N),
        .q(csn_f)
    );

    sbcs_sync #(.RST_VAL(1'b0)) u_sclk
    (
        .clk(CLOCK),
        .rst_n(rst_n),
        .ce(ce),
        .d(SERIAL_CLK),
        .q(sclk_f)
    );

    sbcs_sync #(.RST_VAL(1'b0)) u_sdi
    (
        .clk(CLOCK),
        .rst_n(rst_n),
        .ce(ce),
        .d(SERIAL_IN),
        .q(sdi_f)
    );

    // ----------------------------------------
    // Edge detection and frame supervision
    // ----------------------------------------
    logic csn_d;
    logic sclk_d;
    logic clk_bad;
    logic load_data;
    logic [4:0] fall_cnt;
    logic [4:0] rise_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic sclk_fall;
    logic sclk_rise;
    logic frame_start;
    logic frame_end;
    logic frame_bad;

    assign sclk_fall = sclk_d & ~sclk_f & ~csn_f;
    assign sclk_rise = ~sclk_d & sclk_f & ~csn_f;
    assign frame_start = csn_d & ~csn_f;
    assign frame_end = ~csn_d & csn_f;
    assign frame_bad = clk_bad | sclk_f |
        ((fall_cnt != 5'h00) && (fall_cnt != `SBCS_FRAME_BITS));

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            csn_d <= 1'b1;
            sclk_d <= 1'b0;
        end
        else if (ce)
        begin
            csn_d <= csn_f;
            sclk_d <= sclk_f;
        end
    end

    // Clock high at the opening edge spoils the frame
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            clk_bad <= 1'b0;
        else if (ce && frame_start)
            clk_bad <= sclk_f;
    end

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            fall_cnt <= 5'h00;
        else if (ce)
        begin
            if (frame_start)
                fall_cnt <= 5'h00;
            else if (sclk_fall && fall_cnt != `SBCS_CNT_SAT)
                fall_cnt <= fall_cnt + 5'h01;
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            rise_cnt <= 5'h00;
        else if (ce)
        begin
            if (frame_start)
                rise_cnt <= 5'h00;
            else if (sclk_rise && rise_cnt != `SBCS_FRAME_BITS)
                rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // LSB arrives first, so the word fills from the top
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            rx <= `SBCS_WORD_ZERO;
        else if (ce && sclk_fall)
            rx <= {sdi_f, rx[15:1]};
    end

    // ----------------------------------------
    // Register readback and summary
    // ----------------------------------------
    logic [7:0] ctrl_mem [0:31];
    logic spi_fail;
    logic [7:0] summary;
    logic [7:0] device_byte;

    assign device_byte = STATUS.device | (8'h01 << `SBCS_FAIL_BIT);
    assign summary[0] = |STATUS.supply;
    assign summary[1] = |STATUS.thermal;
    assign summary[2] = |STATUS.device | spi_fail;
    assign summary[3] = |STATUS.bus_one;
    assign summary[4] = |STATUS.bus_two;
    assign summary[5] = |STATUS.wake_one;
    assign summary[6] = |STATUS.wake_two;
    assign summary[7] = |STATUS.switcher;

    function automatic logic [7:0] read_byte(input logic [6:0] a);
        logic [7:0] v;
        v = `SBCS_BYTE_ZERO;
        if (a != `SBCS_ADDR_NONE && a <= `SBCS_ADDR_CTRL_LAST)
            v = ctrl_mem[a[4:0]];
        else
        begin
            unique case (a)
                `SBCS_ADDR_SUPPLY: v = STATUS.supply;
                `SBCS_ADDR_THERMAL: v = STATUS.thermal;
                `SBCS_ADDR_DEVICE: v = spi_fail ? device_byte : STATUS.device;
                `SBCS_ADDR_BUS_STAT_ONE: v = STATUS.bus_one;
                `SBCS_ADDR_BUS_STAT_TWO: v = STATUS.bus_two;
                `SBCS_ADDR_WAKE_STAT_ONE: v = STATUS.wake_one;
                `SBCS_ADDR_WAKE_STAT_TWO: v = STATUS.wake_two;
                `SBCS_ADDR_LEVEL: v = STATUS.level;
                `SBCS_ADDR_SWITCHER: v = STATUS.switcher;
                `SBCS_ADDR_FAMILY: v = STATUS.family;
                default: v = `SBCS_BYTE_ZERO;
            endcase
        end
        return v;
    endfunction

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            load_data <= 1'b0;
        else if (ce)
            load_data <= sclk_fall &&
                (fall_cnt == `SBCS_ADDR_LOAD_FALLS - 5'h01);
    end

    // Summary at frame start, data byte once the address is in
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            tx <= `SBCS_WORD_ZERO;
        else if (ce)
        begin
            if (frame_start)
                tx <= {`SBCS_BYTE_ZERO, summary};
            else if (load_data)
                tx[15:8] <= read_byte(rx[14:8]);
        end
    end

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            SERIAL_OUT <= 1'b0;
            SERIAL_OUT_EN <= 1'b0;
        end
        else if (ce)
        begin
            SERIAL_OUT_EN <= ~csn_f;
            if (frame_start)
                SERIAL_OUT <= ERR_PENDING;
            else if (sclk_rise && rise_cnt != `SBCS_FRAME_BITS)
                SERIAL_OUT <= tx[rise_cnt[3:0]];
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    sbcs_pkg::sbcs_cmd_t cmd;
    logic accept;
    logic is_ctrl;
    logic is_stat;
    logic next_fail;
    logic next_req_stb;
    logic next_wr;
    logic wake_none;
    logic [1:0] req;
    sbcs_pkg::sbcs_target_t next_tgt;

    assign cmd = rx;
    assign req = cmd.data[`SBCS_MODE_HI:`SBCS_MODE_LO];
    assign is_ctrl = cmd.addr != `SBCS_ADDR_NONE &&
        cmd.addr <= `SBCS_ADDR_CTRL_LAST;
    assign is_stat = cmd.addr >= `SBCS_ADDR_SUPPLY;
    assign wake_none =
        ctrl_mem[5'(`SBCS_ADDR_BUS_ONE)] == `SBCS_BYTE_ZERO &&
        ctrl_mem[5'(`SBCS_ADDR_WAKE_TWO)] == `SBCS_BYTE_ZERO;
    assign accept = ce && frame_end && !frame_bad &&
        fall_cnt == `SBCS_FRAME_BITS &&
        CURRENT_MODE != sbcs_pkg::SBCS_RESTART &&
        CURRENT_MODE != sbcs_pkg::SBCS_SLEEP &&
        CURRENT_MODE != sbcs_pkg::SBCS_FAILSAFE;

    always_comb
    begin
        next_fail = 1'b0;
        next_req_stb = 1'b0;
        next_wr = is_ctrl && cmd.rw;
        next_tgt = sbcs_pkg::SBCS_GO_NORMAL;
        if (next_wr && cmd.addr == `SBCS_ADDR_MODE)
        begin
            next_req_stb = 1'b1;
            unique case (req)
                `SBCS_MODE_NORMAL: next_tgt = sbcs_pkg::SBCS_GO_NORMAL;
                `SBCS_MODE_RESET: next_tgt = sbcs_pkg::SBCS_GO_SWRESET;
                `SBCS_MODE_STOP:
                begin
                    if (CURRENT_MODE == sbcs_pkg::SBCS_INIT)
                    begin
                        next_fail = 1'b1;
                        next_wr = 1'b0;
                    end
                    else
                        next_tgt = sbcs_pkg::SBCS_GO_STOP;
                end
                `SBCS_MODE_SLEEP:
                begin
                    next_fail = 1'b1;
                    next_wr = 1'b0;
                    if (CURRENT_MODE == sbcs_pkg::SBCS_INIT)
                        next_tgt = sbcs_pkg::SBCS_GO_NORMAL;
                    else if (CURRENT_MODE == sbcs_pkg::SBCS_STOP)
                        next_tgt = sbcs_pkg::SBCS_GO_RESTART;
                    else if (wake_none)
                        next_tgt = sbcs_pkg::SBCS_GO_RESTART;
                    else
                    begin
                        next_fail = 1'b0;
                        next_wr = 1'b1;
                        next_tgt = sbcs_pkg::SBCS_GO_SLEEP;
                    end
                end
            endcase
        end
        else if (next_wr && CURRENT_MODE == sbcs_pkg::SBCS_STOP &&
            !(cmd.addr == `SBCS_ADDR_WD &&
            cmd.data == ctrl_mem[5'(`SBCS_ADDR_WD)]))
        begin
            next_fail = 1'b1;
            next_wr = 1'b0;
        end
    end

    // ----------------------------------------
    // Command effects
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 32; i++)
                ctrl_mem[i] <= `SBCS_BYTE_ZERO;
        end
        else if (accept && next_wr)
            ctrl_mem[cmd.addr[4:0]] <= cmd.data;
    end

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            WRITE_STB <= 1'b0;
            CLEAR_STB <= 1'b0;
            MODE_REQ_STB <= 1'b0;
            MODE_REQ <= sbcs_pkg::SBCS_GO_NORMAL;
            CMD <= `SBCS_WORD_ZERO;
        end
        else if (ce)
        begin
            WRITE_STB <= accept && next_wr;
            CLEAR_STB <= accept && is_stat && cmd.rw &&
                cmd.addr != `SBCS_ADDR_LEVEL;
            MODE_REQ_STB <= accept && next_req_stb;
            if (accept)
            begin
                MODE_REQ <= next_tgt;
                CMD <= cmd;
            end
        end
    end

    // Bad frame flagged for the next frame; clean frame clears it
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            ERR_PENDING <= 1'b0;
        else if (ce && frame_end)
            ERR_PENDING <= frame_bad;
    end

    // Set beats a clear in the same frame
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            spi_fail <= 1'b0;
        else if (accept && next_fail)
            spi_fail <= 1'b1;
        else if (accept && cmd.rw && cmd.addr == `SBCS_ADDR_DEVICE)
            spi_fail <= 1'b0;
    end

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            SPI_FAIL <= 1'b0;
        else if (ce)
            SPI_FAIL <= spi_fail;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_n);

    sequence frame_close_s;
        ce && frame_end;
    endsequence

    sequence good_frame_s;
        frame_close_s ##0 (!frame_bad && fall_cnt == `SBCS_FRAME_BITS);
    endsequence

    sdo_release_a: assert property (
        frame_close_s ##1 ce |-> ##1 !SERIAL_OUT_EN)
        else $error("serial output still driven after frame end");

    rx_capture_a: assert property (
        ce && sclk_fall |=> rx[15] == $past(sdi_f))
        else $error("serial input not captured on falling edge");

    tx_first_a: assert property (
        ce && sclk_rise && rise_cnt == 5'h00
        |=> SERIAL_OUT == $past(tx[0]))
        else $error("first output bit wrong after rising edge");

    fail_sticky_a: assert property (
        spi_fail && !(accept && cmd.rw && cmd.addr == `SBCS_ADDR_DEVICE)
        |=> spi_fail)
        else $error("fail flag dropped without a clear");

    stop_sleep_a: assert property (
        good_frame_s ##0 (accept && next_wr == 1'b0 &&
        CURRENT_MODE == sbcs_pkg::SBCS_STOP && is_ctrl && cmd.rw &&
        cmd.addr == `SBCS_ADDR_MODE && req == `SBCS_MODE_SLEEP)
        |=> MODE_REQ_STB && MODE_REQ == sbcs_pkg::SBCS_GO_RESTART
        && spi_fail)
        else $error("sleep from stop not turned into restart");

    init_normal_a: assert property (
        accept && cmd.rw && cmd.addr == `SBCS_ADDR_MODE &&
        CURRENT_MODE == sbcs_pkg::SBCS_INIT &&
        (req == `SBCS_MODE_STOP || req == `SBCS_MODE_SLEEP)
        |=> MODE_REQ == sbcs_pkg::SBCS_GO_NORMAL && spi_fail)
        else $error("low power request from init not refused");

    bad_count_a: assert property (
        frame_close_s ##0 frame_bad
        |=> ERR_PENDING && !WRITE_STB && !CLEAR_STB)
        else $error("bad frame not discarded");

    zero_clock_a: assert property (
        frame_close_s ##0 (fall_cnt == 5'h00 && !clk_bad && !sclk_f)
        |=> !ERR_PENDING && !WRITE_STB)
        else $error("zero clock frame raised an error");

    mode_ignore_a: assert property (
        frame_close_s ##0 (CURRENT_MODE == sbcs_pkg::SBCS_SLEEP)
        |=> !WRITE_STB && !CLEAR_STB && !MODE_REQ_STB)
        else $error("command interpreted in sleep");

endmodule

// ===== test/sbcs_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Host controller on the serial link
// ----------------------------------------
module sbcs_host_model
(
    input wire logic clk,
    input wire logic serial_out,
    output logic chip_select_n,
    output logic sclk,
    output logic serial_in
);
    logic err_bit;
    logic [15:0] rx;

    initial
    begin
        chip_select_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
        err_bit = 1'b0;
        rx = 16'h0000;
    end

    // Frame of nclk clocks; hi leaves the clock high at select rise
    task automatic frame(input logic [15:0] tx, input int nclk,
        input logic hi);
        int n;
        @(negedge clk);
        chip_select_n = 1'b0;
        serial_in = tx[0];
        repeat (10) @(negedge clk);
        err_bit = serial_out;
        for (n = 0; n < nclk; n++)
        begin
            sclk = 1'b1;
            serial_in = tx[n % 16];
            repeat (4) @(negedge clk);
            sclk = 1'b0;
            repeat (3) @(negedge clk);
            rx[n % 16] = serial_out;
            @(negedge clk);
        end
        sclk = hi;
        repeat (4) @(negedge clk);
        chip_select_n = 1'b1;
        repeat (4) @(negedge clk);
        sclk = 1'b0;
        // Own frame per target, no chaining
        repeat (12) @(negedge clk);
        serial_in = ~serial_in;
    endtask
endmodule

// ===== test/tb_sbc_spi_command_interface.sv
`timescale 1ns/100ps
`include "sbcs_consts.svh"

module tb_sbc_spi_command_interface;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic chip_select_n, sclk, serial_in, serial_out, sdo_en, fail, err_p, mstb, wstb, cstb;
    wire sdo_line;
    sbcs_pkg::sbcs_mode_t mode = sbcs_pkg::SBCS_NORMAL;
    sbcs_pkg::sbcs_status_t status = '0;
    sbcs_pkg::sbcs_target_t mreq;
    sbcs_pkg::sbcs_cmd_t cmd;
    logic [3:0] wr_n = 4'h0;
    logic [3:0] clr_n = 4'h0;
    logic [3:0] md_n = 4'h0;
    logic [3:0] w0, c0, m0;
    int err_total = 0;
    int total_checks = 0;

    always #20 clock = ~clock;
    assign sdo_line = sdo_en ? serial_out : 1'bz;

    sbcs_spi_target dut
    (
        .CLOCK(clock),
        .RST_N(rst_n),
        .CLOCK_EN(ce),
        .CHIP_SELECT_N(chip_select_n),
        .SERIAL_CLK(sclk),
        .SERIAL_IN(serial_in),
        .SERIAL_OUT(serial_out),
        .SERIAL_OUT_EN(sdo_en),
        .CURRENT_MODE(mode),
        .STATUS(status),
        .SPI_FAIL(fail),
        .ERR_PENDING(err_p),
        .MODE_REQ_STB(mstb),
        .MODE_REQ(mreq),
        .WRITE_STB(wstb),
        .CLEAR_STB(cstb),
        .CMD(cmd)
    );

    sbcs_host_model host
    (
        .clk(clock),
        .serial_out(sdo_line),
        .chip_select_n(chip_select_n),
        .sclk(sclk),
        .serial_in(serial_in)
    );

    always @(posedge clock)
    begin
        wr_n <= wr_n + {3'h0, wstb};
        clr_n <= clr_n + {3'h0, cstb};
        md_n <= md_n + {3'h0, mstb};
    end

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic xfer(input logic [6:0] a, input logic rw,
        input logic [7:0] d, input int nclk = 16, input logic hi = 1'b0);
        w0 = wr_n;
        c0 = clr_n;
        m0 = md_n;
        host.frame({d, rw, a}, nclk, hi);
        chk({15'h0, sdo_en}, 16'h0000);
    endtask

    // Strobe counts since frame start: write, clear, mode
    task automatic stb(input logic [11:0] e);
        chk({4'h0, wr_n - w0, clr_n - c0, md_n - m0}, {4'h0, e});
    endtask

    task automatic mode_case(input sbcs_pkg::sbcs_mode_t m,
        input logic [7:0] d, input sbcs_pkg::sbcs_target_t t,
        input logic f);
        mode = m;
        xfer(`SBCS_ADDR_MODE, 1'b1, d);
        chk({8'h0, md_n - m0, fail, mreq}, {8'h0, 4'h1, f, t});
        if (f)
        begin
            xfer(`SBCS_ADDR_BUS_ONE, 1'b0, 8'h00);
            chk({15'h0, fail}, 16'h0001);
            xfer(`SBCS_ADDR_DEVICE, 1'b1, 8'h00);
            chk({15'h0, fail}, 16'h0000);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        chk({fail, err_p, mstb, wstb, cstb, sdo_en, 10'h0}, 16'h0000);
        chk(cmd, 16'h0000);
        xfer(7'h00, 1'b0, 8'h00, 0);
        chk({14'h0, host.err_bit, err_p}, 16'h0000);
        stb(12'h000);
        status = {8'h33, 8'h00, 8'hFF, 8'h02, 8'h00,
            8'h10, 8'h00, 8'h80, 8'h00, 8'h01};
        xfer(`SBCS_ADDR_BUS_ONE, 1'b1, 8'hA5);
        stb(12'h100);
        chk(cmd, 16'hA584);
        chk(host.rx, 16'h0055);
        xfer(`SBCS_ADDR_BUS_ONE, 1'b0, 8'h00);
        stb(12'h000);
        chk(host.rx, 16'hA555);
        status = {8'h00, 8'h08, 8'h00, 8'h00, 8'h40,
            8'h00, 8'h01, 8'h00, 8'h24, 8'h00};
        xfer(`SBCS_ADDR_THERMAL, 1'b0, 8'h00);
        chk(host.rx, 16'h24AA);
        xfer(`SBCS_ADDR_THERMAL, 1'b1, 8'h00);
        stb(12'h010);
        chk(cmd, 16'h00C2);
        xfer(`SBCS_ADDR_LEVEL, 1'b1, 8'h00);
        stb(12'h000);
        // Wrong clock count of fifteen and clock high at select rise
        xfer(`SBCS_ADDR_BUS_ONE, 1'b1, 8'h11, 15);
        stb(12'h000);
        chk({15'h0, err_p}, 16'h0001);
        xfer(`SBCS_ADDR_BUS_ONE, 1'b0, 8'h00);
        chk({14'h0, host.err_bit, err_p}, 16'h0002);
        chk(host.rx, 16'hA5AA);
        xfer(`SBCS_ADDR_BUS_ONE, 1'b1, 8'h22, 16, 1'b1);
        stb(12'h000);
        xfer(7'h00, 1'b0, 8'h00, 0);
        chk({14'h0, host.err_bit, err_p}, 16'h0002);
        // Mode requests
        mode_case(sbcs_pkg::SBCS_NORMAL, 8'h40, sbcs_pkg::SBCS_GO_SLEEP,
            1'b0);
        mode_case(sbcs_pkg::SBCS_NORMAL, 8'hC0, sbcs_pkg::SBCS_GO_SWRESET,
            1'b0);
        mode_case(sbcs_pkg::SBCS_STOP, 8'h00, sbcs_pkg::SBCS_GO_NORMAL,
            1'b0);
        mode_case(sbcs_pkg::SBCS_STOP, 8'h40, sbcs_pkg::SBCS_GO_RESTART,
            1'b1);
        mode_case(sbcs_pkg::SBCS_INIT, 8'h80, sbcs_pkg::SBCS_GO_NORMAL,
            1'b1);
        mode_case(sbcs_pkg::SBCS_INIT, 8'h40, sbcs_pkg::SBCS_GO_NORMAL,
            1'b1);
        mode = sbcs_pkg::SBCS_STOP;
        xfer(`SBCS_ADDR_WD, 1'b1, 8'h12);
        stb(12'h000);
        chk({15'h0, fail}, 16'h0001);
        xfer(`SBCS_ADDR_DEVICE, 1'b1, 8'h00);
        xfer(`SBCS_ADDR_WD, 1'b1, 8'h00);
        stb(12'h100);
        chk({15'h0, fail}, 16'h0000);
        mode = sbcs_pkg::SBCS_NORMAL;
        xfer(`SBCS_ADDR_BUS_ONE, 1'b1, 8'h00);
        mode_case(sbcs_pkg::SBCS_NORMAL, 8'h40, sbcs_pkg::SBCS_GO_RESTART,
            1'b1);
        mode_case(sbcs_pkg::SBCS_NORMAL, 8'h80, sbcs_pkg::SBCS_GO_STOP,
            1'b0);
        // Silent modes
        mode = sbcs_pkg::SBCS_RESTART;
        xfer(`SBCS_ADDR_BUS_ONE, 1'b1, 8'h5A);
        stb(12'h000);
        mode = sbcs_pkg::SBCS_SLEEP;
        xfer(`SBCS_ADDR_MODE, 1'b1, 8'h00);
        stb(12'h000);
        mode = sbcs_pkg::SBCS_FAILSAFE;
        xfer(`SBCS_ADDR_BUS_ONE, 1'b1, 8'h5A);
        stb(12'h000);
        mode = sbcs_pkg::SBCS_NORMAL;
        ce = 1'b0;
        xfer(`SBCS_ADDR_BUS_ONE, 1'b1, 8'h77);
        stb(12'h000);
        ce = 1'b1;
        xfer(`SBCS_ADDR_BUS_ONE, 1'b0, 8'h00);
        chk(host.rx, 16'h00AA);
        test_done();
    end
endmodule
